// File: verilog/sdr_top.sv
// Contract
// - Input and fan-out strap pins resolve to L, R, F or H at 0.2/0.5/0.8 supply; loop-through only to L or H.
// - An open strap pin decodes as float, the default for every strap.
// - Input strap H or F picks primary coax, R or L picks secondary.
// - Register override bits can select either coax input regardless of pin.
// - Fan-out strap H disables both, F or L enables A, R enables both.
// - Loop-through strap high disables the coax loop output, low enables it.
// - Power-save is entered automatically when the selected input has no carrier.
// - Enable pin low forces power-save regardless of carrier.
// - One status output selectable as lock, carrier detect or interrupt.
// - Reclocked data fans out to three outputs, each gated by its enable.
// - Reclocker needs no reference clock; lock comes from recovered data.
// - Returning carrier makes the device leave power-save by itself.
// - Carrier detect and register access stay active in power-save.
`timescale 1ns/1ps

module sdr_top #(
   parameter int FILT_LEN = sdr_pkg::STRAP_FILT_LEN,
   parameter logic [31:0] ID_VALUE = sdr_pkg::ID_DEFAULT
) (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // Avalon-MM slave
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // Strap comparators, bit 0/1/2 at 0.2/0.5/0.8 of supply
   input wire logic [2:0] I_IN_SEL_STRAP_CMP,
   input wire logic [2:0] I_FANOUT_STRAP_CMP,
   input wire logic I_LOOP_THROUGH_ENABLE_STRAP,
   input wire logic I_ENABLE,
   // Analog front end status
   input wire logic I_CD_PRIMARY,
   input wire logic I_CD_SECONDARY,
   input wire logic I_CDR_LOCK,
   input wire logic I_RECLK_DATA,
   // Routing and outputs
   output logic O_IN_SEL_SECONDARY,
   output logic O_POWER_SAVE,
   output logic O_DIFF_OUTPUT_A,
   output logic O_DIFF_OUTPUT_B,
   output logic O_COAX_LOOP_OUTPUT,
   output logic O_STATUS_PIN
);

   localparam int NSTRAP = 3;

   sdr_pkg::sdr_lvl_e lvl [NSTRAP];
   logic [2:0] strap_cmp [NSTRAP];
   logic [3:0] async1_q;
   logic [3:0] async2_q;
   logic en_s;
   logic cd_pri_s;
   logic cd_sec_s;
   logic lock_s;
   logic data1_q;
   logic data2_q;
   logic [sdr_pkg::CTRL_W-1:0] ctrl_q;
   logic [sdr_pkg::EVT_W-1:0] evt_q;
   logic [sdr_pkg::EVT_W-1:0] evt_set;
   logic [sdr_pkg::EVT_W-1:0] evt_clr;
   logic in_sec_q;
   logic en_a_q;
   logic en_b_q;
   logic en_loop_q;
   logic ps_q;
   logic lock_prev_q;
   logic cd_prev_q;
   logic cd_sel;
   logic irq;
   logic [1:0] stat_sel;
   logic wait_q;
   logic req;
   logic wr_take;
   logic [31:0] rdata_q;
   logic [31:0] status_word;

   // ****************************************************************
   // Strap decode
   // ****************************************************************
   assign strap_cmp[0] = I_IN_SEL_STRAP_CMP;
   assign strap_cmp[1] = I_FANOUT_STRAP_CMP;
   assign strap_cmp[2] = {3{I_LOOP_THROUGH_ENABLE_STRAP}};

   // One filter per strap pin
   generate
      for (genvar g = 0; g < NSTRAP; g++)
      begin : g_strap
         sdr_strap_filt #(
            .FILT_LEN(FILT_LEN)
         ) u_filt (
            .i_clk(I_CLK_SYS),
            .i_rst_n(I_RESETN),
            .i_cmp(strap_cmp[g]),
            .o_level(lvl[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Pin synchronizers
   // ****************************************************************
   // Enable, carrier detects and lock pass two flops
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         async1_q <= 4'h0;
         async2_q <= 4'h0;
      end
      else
      begin
         async1_q <= {I_CDR_LOCK, I_CD_SECONDARY, I_CD_PRIMARY, I_ENABLE};
         async2_q <= async1_q;
      end
   end

   assign en_s = async2_q[0];
   assign cd_pri_s = async2_q[1];
   assign cd_sec_s = async2_q[2];
   assign lock_s = async2_q[3];

   // Reclocked data synchronizer
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         data1_q <= 1'b0;
         data2_q <= 1'b0;
      end
      else
      begin
         data1_q <= I_RECLK_DATA;
         data2_q <= data1_q;
      end
   end

   // ****************************************************************
   // Routing selection
   // ****************************************************************
   // Override bits win only while their enable bit is set
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         in_sec_q <= 1'b0;
         en_a_q <= 1'b1;
         en_b_q <= 1'b0;
         en_loop_q <= 1'b1;
      end
      else
      begin
         if (ctrl_q[sdr_pkg::CTRL_IN_OVR_EN])
            in_sec_q <= ctrl_q[sdr_pkg::CTRL_IN_OVR_SEC];
         else
            in_sec_q <= (lvl[0] == sdr_pkg::LVL_R) || (lvl[0] == sdr_pkg::LVL_L);
         if (ctrl_q[sdr_pkg::CTRL_FAN_OVR_EN])
         begin
            en_a_q <= ctrl_q[sdr_pkg::CTRL_FAN_A_EN];
            en_b_q <= ctrl_q[sdr_pkg::CTRL_FAN_B_EN];
         end
         else
         begin
            en_a_q <= (lvl[1] != sdr_pkg::LVL_H);
            en_b_q <= (lvl[1] == sdr_pkg::LVL_R);
         end
         if (ctrl_q[sdr_pkg::CTRL_LOOP_OVR_EN])
            en_loop_q <= ctrl_q[sdr_pkg::CTRL_LOOP_EN];
         else
            en_loop_q <= (lvl[2] != sdr_pkg::LVL_H);
      end
   end

   // ****************************************************************
   // Power save
   // ****************************************************************
   // Carrier detect stays live in power-save
   assign cd_sel = in_sec_q ? cd_sec_s : cd_pri_s;

   // No carrier or enable low puts the device to sleep, carrier wakes it
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         ps_q <= 1'b1;
      else
         ps_q <= !en_s || !cd_sel;
   end

   // ****************************************************************
   // Fan-out
   // ****************************************************************
   // Each output carries reclocked data only while enabled and awake
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_DIFF_OUTPUT_A <= 1'b0;
         O_DIFF_OUTPUT_B <= 1'b0;
         O_COAX_LOOP_OUTPUT <= 1'b0;
      end
      else
      begin
         O_DIFF_OUTPUT_A <= data2_q && en_a_q && !ps_q;
         O_DIFF_OUTPUT_B <= data2_q && en_b_q && !ps_q;
         O_COAX_LOOP_OUTPUT <= data2_q && en_loop_q && !ps_q;
      end
   end

   // Routing flags to pins
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_IN_SEL_SECONDARY <= 1'b0;
         O_POWER_SAVE <= 1'b1;
      end
      else
      begin
         O_IN_SEL_SECONDARY <= in_sec_q;
         O_POWER_SAVE <= ps_q;
      end
   end

   // ****************************************************************
   // Events and status pin
   // ****************************************************************
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         lock_prev_q <= 1'b0;
         cd_prev_q <= 1'b0;
      end
      else
      begin
         lock_prev_q <= lock_s;
         cd_prev_q <= cd_sel;
      end
   end

   assign evt_set[sdr_pkg::EVT_LOCK_LOST] = lock_prev_q && !lock_s;
   assign evt_set[sdr_pkg::EVT_CD_LOST] = cd_prev_q && !cd_sel;
   assign evt_set[sdr_pkg::EVT_PS_ENTER] = !ps_q && (!en_s || !cd_sel);
   assign evt_clr = (wr_take && (I_AVS_ADDRESS == sdr_pkg::REG_EVENT) && I_AVS_BYTEENABLE[0])
      ? I_AVS_WRITEDATA[sdr_pkg::EVT_W-1:0] : '0;

   // Sticky events, write one to clear, a new event beats the clear
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         evt_q <= '0;
      else
         evt_q <= (evt_q & ~evt_clr) | evt_set;
   end

   assign irq = |evt_q;
   assign stat_sel = ctrl_q[sdr_pkg::CTRL_STAT_SEL_LO +: 2];

   // Status pin source picked by software
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         O_STATUS_PIN <= 1'b0;
      else
      begin
         case (stat_sel)
            sdr_pkg::STAT_SEL_LOCK: O_STATUS_PIN <= lock_s;
            sdr_pkg::STAT_SEL_CD: O_STATUS_PIN <= cd_sel;
            sdr_pkg::STAT_SEL_IRQ: O_STATUS_PIN <= irq;
            default: O_STATUS_PIN <= 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   assign req = I_AVS_READ || I_AVS_WRITE;
   assign wr_take = I_AVS_WRITE && !wait_q;

   // One wait cycle per access, served in power-save as well
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         wait_q <= 1'b1;
      else
         wait_q <= !(req && wait_q);
   end

   assign status_word = {18'h00000, ps_q, lock_s, cd_sel, in_sec_q,
      en_loop_q, en_b_q, en_a_q, 1'b0, lvl[2], lvl[1], lvl[0]};

   // Read data captured in the wait cycle
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         rdata_q <= 32'h0000_0000;
      else if (I_AVS_READ && wait_q)
      begin
         case (I_AVS_ADDRESS)
            sdr_pkg::REG_CTRL: rdata_q <= {22'h000000, ctrl_q};
            sdr_pkg::REG_STATUS: rdata_q <= status_word;
            sdr_pkg::REG_EVENT: rdata_q <= {29'h00000000, evt_q};
            sdr_pkg::REG_ID: rdata_q <= ID_VALUE;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Control register with byte lanes
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
         ctrl_q <= sdr_pkg::CTRL_RESET;
      else if (wr_take && (I_AVS_ADDRESS == sdr_pkg::REG_CTRL))
      begin
         if (I_AVS_BYTEENABLE[0])
            ctrl_q[7:0] <= I_AVS_WRITEDATA[7:0];
         if (I_AVS_BYTEENABLE[1])
            ctrl_q[9:8] <= I_AVS_WRITEDATA[9:8];
      end
   end

   assign O_AVS_READDATA = rdata_q;
   assign O_AVS_WAITREQUEST = wait_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_no_carrier;
      !cd_sel && en_s;
   endsequence

   sequence s_wake;
      en_s && cd_sel && ps_q;
   endsequence

   sequence s_bus_req;
      req && wait_q;
   endsequence

   a_in_strap_route: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      (!ctrl_q[sdr_pkg::CTRL_IN_OVR_EN] && (lvl[0] == sdr_pkg::LVL_H
      || lvl[0] == sdr_pkg::LVL_F)) |=> !in_sec_q)
      else $error("primary input not routed for high or float strap");

   a_in_override: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      ctrl_q[sdr_pkg::CTRL_IN_OVR_EN] |=> in_sec_q == $past(ctrl_q[sdr_pkg::CTRL_IN_OVR_SEC]))
      else $error("input override not applied");

   a_fan_both: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      (!ctrl_q[sdr_pkg::CTRL_FAN_OVR_EN] && lvl[1] == sdr_pkg::LVL_R) |=> en_a_q && en_b_q)
      else $error("fan-out strap R did not enable both outputs");

   a_fan_none: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      (!ctrl_q[sdr_pkg::CTRL_FAN_OVR_EN] && lvl[1] == sdr_pkg::LVL_H) |=> !en_a_q && !en_b_q)
      else $error("fan-out strap H did not disable outputs");

   a_loop_strap: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      !ctrl_q[sdr_pkg::CTRL_LOOP_OVR_EN] |=> en_loop_q == ($past(lvl[2]) != sdr_pkg::LVL_H))
      else $error("loop-through enable mismatches strap");

   a_ps_auto: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      s_no_carrier |=> ps_q ##1 O_POWER_SAVE)
      else $error("no power-save on lost carrier");

   a_ps_forced: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      !en_s |=> ps_q)
      else $error("enable low did not force power-save");

   a_ps_exit: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      s_wake |=> !ps_q ##1 !O_POWER_SAVE)
      else $error("power-save not left on carrier return");

   a_out_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      (ps_q || !en_a_q) |=> !O_DIFF_OUTPUT_A)
      else $error("output A driven while gated");

   a_bus_live: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      s_bus_req |=> !O_AVS_WAITREQUEST)
      else $error("bus access not answered in one wait cycle");

   a_status_cd: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
      (stat_sel == sdr_pkg::STAT_SEL_CD) |=> O_STATUS_PIN == $past(cd_sel))
      else $error("status pin not showing carrier detect");

endmodule : sdr_top

// File: verilog/sdr_pkg.sv
package sdr_pkg;

   // ****************************************************************
   // Strap levels and thresholds
   // ****************************************************************
   // Four strap levels, ordered from lowest to highest pin voltage
   typedef enum logic [1:0] {LVL_L, LVL_R, LVL_F, LVL_H} sdr_lvl_e;

   // Comparator decision points in percent of supply_voltage
   localparam int THR_L_R_PCT = 20;
   localparam int THR_R_F_PCT = 50;
   localparam int THR_F_H_PCT = 80;
   // Open pin bias point in percent of supply_voltage (2/3)
   localparam int FLOAT_BIAS_PCT = 67;

   // Comparator vector bit positions
   localparam int CMP_LR = 0;
   localparam int CMP_RF = 1;
   localparam int CMP_FH = 2;

   // Default number of matching samples before a strap level is taken
   localparam int STRAP_FILT_LEN = 4;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_EVENT = 4'h8;
   localparam logic [3:0] REG_ID = 4'hC;

   // Control register fields
   localparam int CTRL_IN_OVR_EN = 0;
   localparam int CTRL_IN_OVR_SEC = 1;
   localparam int CTRL_FAN_OVR_EN = 2;
   localparam int CTRL_FAN_A_EN = 3;
   localparam int CTRL_FAN_B_EN = 4;
   localparam int CTRL_LOOP_OVR_EN = 5;
   localparam int CTRL_LOOP_EN = 6;
   localparam int CTRL_STAT_SEL_LO = 8;
   localparam int CTRL_W = 10;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

   // Status pin sources
   localparam logic [1:0] STAT_SEL_LOCK = 2'h0;
   localparam logic [1:0] STAT_SEL_CD = 2'h1;
   localparam logic [1:0] STAT_SEL_IRQ = 2'h2;

   // Event register fields
   localparam int EVT_LOCK_LOST = 0;
   localparam int EVT_CD_LOST = 1;
   localparam int EVT_PS_ENTER = 2;
   localparam int EVT_W = 3;

   // Identification value, arbitrary
   localparam logic [31:0] ID_DEFAULT = 32'h0000_5A01;

endpackage : sdr_pkg

// File: verilog/sdr_strap_filt.sv
`timescale 1ns/1ps

module sdr_strap_filt #(
   parameter int FILT_LEN = sdr_pkg::STRAP_FILT_LEN
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Raw comparator outputs from the pin
   input wire logic [2:0] i_cmp,
   // Filtered level
   output sdr_pkg::sdr_lvl_e o_level
);

   localparam int CW = $clog2(FILT_LEN + 1);

   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   sdr_pkg::sdr_lvl_e cand_d;
   sdr_pkg::sdr_lvl_e cand_q;
   sdr_pkg::sdr_lvl_e level_q;
   logic [CW-1:0] cnt_q;

   // ****************************************************************
   // Synchronizer
   // ****************************************************************
   // Two flops before any decode
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end
      else
      begin
         sync1_q <= i_cmp;
         sync2_q <= sync1_q;
      end
   end

   // Thresholds at 0.2, 0.5 and 0.8 of supply resolve to one of four levels
   always_comb
   begin
      if (sync2_q[sdr_pkg::CMP_FH])
         cand_d = sdr_pkg::LVL_H;
      else if (sync2_q[sdr_pkg::CMP_RF])
         cand_d = sdr_pkg::LVL_F;
      else if (sync2_q[sdr_pkg::CMP_LR])
         cand_d = sdr_pkg::LVL_R;
      else
         cand_d = sdr_pkg::LVL_L;
   end

   // ****************************************************************
   // Consecutive-sample filter
   // ****************************************************************
   // Level only moves after FILT_LEN + 1 equal samples; open pin reads float
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cand_q <= sdr_pkg::LVL_F;
         level_q <= sdr_pkg::LVL_F;
         cnt_q <= '0;
      end
      else
      begin
         cand_q <= cand_d;
         if (cand_d != cand_q)
            cnt_q <= '0;
         else if (cnt_q != CW'(FILT_LEN - 1))
            cnt_q <= cnt_q + 1'b1;
         else
            level_q <= cand_q;
      end
   end

   assign o_level = level_q;

   // Level changes only after a full run of matching samples
   a_filt_run_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (level_q != $past(level_q)) |-> ($past(cnt_q) == CW'(FILT_LEN - 1)))
      else $error("strap level changed before filter run completed");

endmodule : sdr_strap_filt

// File: tb/sdr_strap_model.sv
`timescale 1ns/1ps

module sdr_strap_model (
   // Strap settings chosen by the bench
   input wire logic i_in_open,
   input wire sdr_pkg::sdr_lvl_e i_in_lvl,
   input wire logic i_fan_open,
   input wire sdr_pkg::sdr_lvl_e i_fan_lvl,
   // Comparator outputs seen by the device
   output logic [2:0] o_in_cmp,
   output logic [2:0] o_fan_cmp
);

   // ****************************************************************
   // Pin voltage and four-level comparators
   // ****************************************************************
   // Pin voltage in percent of supply_voltage; open pin sits at 2/3
   function automatic int pin_pct(input logic open, input sdr_pkg::sdr_lvl_e lvl);
      if (open) return sdr_pkg::FLOAT_BIAS_PCT;
      case (lvl)
         sdr_pkg::LVL_H: return 100;
         sdr_pkg::LVL_F: return 67;
         sdr_pkg::LVL_R: return 33;
         default: return 0;
      endcase
   endfunction : pin_pct

   // Compare against the three decision points
   function automatic logic [2:0] cmp(input int p);
      return {p > sdr_pkg::THR_F_H_PCT, p > sdr_pkg::THR_R_F_PCT,
              p > sdr_pkg::THR_L_R_PCT};
   endfunction : cmp

   // Resolved comparator vectors
   assign o_in_cmp = cmp(pin_pct(i_in_open, i_in_lvl));
   assign o_fan_cmp = cmp(pin_pct(i_fan_open, i_fan_lvl));

endmodule : sdr_strap_model

// File: tb/sdr_top_tb.sv
`timescale 1ns/1ps

module sdr_top_tb;

   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int FL = 2;
   localparam logic [31:0] IDV = 32'h0000_3C5A; // Arbitrary value
   logic I_CLK_SYS = 1'b0, I_RESETN = 1'b0;
   logic [3:0] I_AVS_ADDRESS = 4'h0;
   logic I_AVS_READ = 1'b0, I_AVS_WRITE = 1'b0;
   logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, q;
   logic O_AVS_WAITREQUEST, loop_s = 1'b0, en = 1'b1, cdp = 1'b1, cds = 1'b1;
   logic lock = 1'b0, in_open = 1'b1, fan_open = 1'b1, dat = 1'b1;
   logic O_IN_SEL_SECONDARY, O_POWER_SAVE, O_DIFF_OUTPUT_A, O_DIFF_OUTPUT_B;
   logic O_COAX_LOOP_OUTPUT, O_STATUS_PIN;
   logic [2:0] in_cmp, fan_cmp;
   sdr_pkg::sdr_lvl_e in_lvl = sdr_pkg::LVL_F, fan_lvl = sdr_pkg::LVL_F;
   int failures = 0, num_checks = 0;

   // Board straps
   sdr_strap_model u_straps (.i_in_open(in_open), .i_in_lvl(in_lvl),
      .i_fan_open(fan_open), .i_fan_lvl(fan_lvl), .o_in_cmp(in_cmp), .o_fan_cmp(fan_cmp));

   // Device under test
   sdr_top #(.FILT_LEN(FL), .ID_VALUE(IDV)) u_dut (.I_CLK_SYS(I_CLK_SYS),
      .I_RESETN(I_RESETN), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
      .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(4'h3),
      .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
      .I_IN_SEL_STRAP_CMP(in_cmp), .I_FANOUT_STRAP_CMP(fan_cmp),
      .I_LOOP_THROUGH_ENABLE_STRAP(loop_s), .I_ENABLE(en), .I_CD_PRIMARY(cdp),
      .I_CD_SECONDARY(cds), .I_CDR_LOCK(lock), .I_RECLK_DATA(dat),
      .O_IN_SEL_SECONDARY(O_IN_SEL_SECONDARY), .O_POWER_SAVE(O_POWER_SAVE),
      .O_DIFF_OUTPUT_A(O_DIFF_OUTPUT_A), .O_DIFF_OUTPUT_B(O_DIFF_OUTPUT_B),
      .O_COAX_LOOP_OUTPUT(O_COAX_LOOP_OUTPUT), .O_STATUS_PIN(O_STATUS_PIN));

   // 50 MHz clock
   always #10 I_CLK_SYS = ~I_CLK_SYS;

   // ****************************************************************
   // Tasks
   // ****************************************************************
   // Compare and count
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge I_CLK_SYS);
      I_AVS_ADDRESS <= a;
      I_AVS_WRITEDATA <= d;
      I_AVS_READ <= !wr;
      I_AVS_WRITE <= wr;
      do
      begin
         @(posedge I_CLK_SYS);
         n++;
      end
      while (O_AVS_WAITREQUEST !== 1'b0 && n < 50);
      q = O_AVS_READDATA;
      I_AVS_READ <= 1'b0;
      I_AVS_WRITE <= 1'b0;
      // A slave that never answers ends the run as a failure
      if (n >= 50)
      begin
         check("waitrequest", 1'b1, 1'b0);
         end_sim();
      end
   endtask : bus

   // Let a number of clock edges pass
   task automatic cyc(input int n);
      repeat (n) @(posedge I_CLK_SYS);
   endtask : cyc

   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // ****************************************************************
   // Tests
   // ****************************************************************
   // Main sequence
   initial
   begin
      cyc(6);
      I_RESETN <= 1'b1;
      cyc(12);
      // Open pins and reset values
      bus(0, sdr_pkg::REG_STATUS, 0); check("status_open", q[5:0], 6'h0A);
      check("sel_open", O_IN_SEL_SECONDARY, 1'b0);
      bus(0, sdr_pkg::REG_CTRL, 0); check("ctrl_rst", q, 32'h0);
      bus(0, sdr_pkg::REG_ID, 0); check("id", q, IDV);
      bus(1, sdr_pkg::REG_ID, 32'h0); bus(0, sdr_pkg::REG_ID, 0); check("id_ro", q, IDV);
      bus(0, 4'h2, 0); check("unmapped", q, 32'h0);
      // Strap table over all four levels
      in_open <= 1'b0;
      fan_open <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         in_lvl <= sdr_pkg::sdr_lvl_e'(i);
         fan_lvl <= sdr_pkg::sdr_lvl_e'(i);
         loop_s <= i[0];
         cyc(12);
         bus(0, sdr_pkg::REG_STATUS, 0);
         check("status", q[13:0], {3'b001, i < 2, !i[0], i == 1, i != 3, 1'b0,
            {2{i[0]}}, i[1:0], i[1:0]});
         check("pins", {O_IN_SEL_SECONDARY, O_DIFF_OUTPUT_A, O_DIFF_OUTPUT_B,
            O_COAX_LOOP_OUTPUT}, {i < 2, i != 3, i == 1, !i[0]});
         // Enabled outputs follow the data, not just their enable
         if (i == 1)
         begin
            dat <= 1'b0;
            cyc(6);
            check("data_low", {O_DIFF_OUTPUT_A, O_DIFF_OUTPUT_B}, 2'b00);
            dat <= 1'b1;
            cyc(6);
         end
      end
      // Overrides with and without their enables
      bus(1, sdr_pkg::REG_CTRL, 32'h37); cyc(4);
      bus(0, sdr_pkg::REG_CTRL, 0); check("ctrl_rw", q, 32'h37);
      check("ovr_on", {O_IN_SEL_SECONDARY, O_DIFF_OUTPUT_A, O_DIFF_OUTPUT_B,
         O_COAX_LOOP_OUTPUT}, 4'hA);
      bus(1, sdr_pkg::REG_CTRL, 32'h5A); cyc(4);
      check("ovr_off", {O_IN_SEL_SECONDARY, O_DIFF_OUTPUT_A, O_DIFF_OUTPUT_B,
         O_COAX_LOOP_OUTPUT}, 4'h0);
      // One-cycle strap glitch is filtered out
      in_open <= 1'b1;
      fan_open <= 1'b1;
      cyc(12);
      in_lvl <= sdr_pkg::LVL_L;
      in_open <= 1'b0;
      cyc(1);
      in_open <= 1'b1;
      cyc(12);
      check("glitch", O_IN_SEL_SECONDARY, 1'b0);
      // Carrier loss on the selected input
      bus(1, sdr_pkg::REG_CTRL, 32'h0);
      bus(1, sdr_pkg::REG_EVENT, 32'h7);
      cdp <= 1'b0;
      cyc(6);
      check("ps_auto", O_POWER_SAVE, 1'b1);
      check("ps_gate", O_DIFF_OUTPUT_A, 1'b0);
      bus(0, sdr_pkg::REG_EVENT, 0); check("evt_ps", q[2:0], 3'h6);
      bus(0, sdr_pkg::REG_STATUS, 0); check("st_ps", {q[13], q[11]}, 2'b10);
      bus(1, sdr_pkg::REG_CTRL, 32'h3); cyc(6);
      check("ps_sec", O_POWER_SAVE, 1'b0);
      bus(1, sdr_pkg::REG_CTRL, 32'h0); cdp <= 1'b1; cyc(6);
      check("ps_exit", O_POWER_SAVE, 1'b0);
      check("ps_data", O_DIFF_OUTPUT_A, 1'b1);
      // Enable pin forces power save with carrier present
      en <= 1'b0; cyc(6); check("ps_en", O_POWER_SAVE, 1'b1);
      en <= 1'b1; cyc(6); check("ps_en_off", O_POWER_SAVE, 1'b0);
      // Status pin sources
      bus(1, sdr_pkg::REG_EVENT, 32'h7); bus(0, sdr_pkg::REG_EVENT, 0);
      check("evt_clr", q[2:0], 3'h0);
      lock <= 1'b1; cyc(6); check("stat_lock", O_STATUS_PIN, 1'b1);
      bus(1, sdr_pkg::REG_CTRL, 32'h100); cyc(4); check("stat_cd", O_STATUS_PIN, 1'b1);
      // Carrier loss with lock still high tells carrier apart from lock
      cdp <= 1'b0;
      cyc(6);
      check("stat_cd0", O_STATUS_PIN, 1'b0);
      cdp <= 1'b1;
      cyc(6);
      bus(1, sdr_pkg::REG_EVENT, 32'h7);
      bus(1, sdr_pkg::REG_CTRL, 32'h200); cyc(4); check("stat_irq0", O_STATUS_PIN, 1'b0);
      lock <= 1'b0; cyc(6); check("stat_irq1", O_STATUS_PIN, 1'b1);
      bus(1, sdr_pkg::REG_CTRL, 32'h300); cyc(4); check("stat_zero", O_STATUS_PIN, 1'b0);
      end_sim();
   end

   // Watchdog
   initial
   begin
      cyc(5000);
      failures++;
      end_sim();
   end

endmodule : sdr_top_tb
